// >>> hdl/ssu_pkg.sv
// package for the scaled subtract unit: ops, condition codes, bus map, carriers
package ssu_pkg;
  localparam int DATA_W = 32;
  localparam int SIGN_BIT = 31;
  localparam int REG_ADDR_W = 6;
  localparam logic [5:0] NO_RESULT_DEST = 6'h3E;
  localparam logic [5:0] STACK_PTR_IDX = 6'h1C;
  localparam int SP_IMM_W = 5;
  localparam int SP_ALIGN_SHIFT = 2;
  localparam logic [1:0] SP_ALIGN_ZERO = 2'h0;

  typedef enum logic [2:0] {
    SSU_OP_SUB = 3'b000,
    SSU_OP_SUB_X2 = 3'b001,
    SSU_OP_SUB_X4 = 3'b010,
    SSU_OP_SUB_X8 = 3'b011,
    SSU_OP_CLEAR_NE = 3'b100,
    SSU_OP_SP_IMM = 3'b101
  } ssu_op_e;

  localparam logic [4:0] CC_ALWAYS = 5'h00;
  localparam logic [4:0] CC_EQ = 5'h01;
  localparam logic [4:0] CC_NE = 5'h02;
  localparam logic [4:0] CC_PL = 5'h03;
  localparam logic [4:0] CC_MI = 5'h04;
  localparam logic [4:0] CC_CS = 5'h05;
  localparam logic [4:0] CC_CC = 5'h06;
  localparam logic [4:0] CC_VS = 5'h07;
  localparam logic [4:0] CC_VC = 5'h08;

  // register byte addresses
  localparam logic [3:0] ADDR_SRC1 = 4'h0;
  localparam logic [3:0] ADDR_SRC2 = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h8;
  localparam logic [3:0] ADDR_RESULT = 4'hC;
  // cmd fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_CC_LSB = 4;
  localparam int CMD_SETF_BIT = 9;
  localparam int CMD_DEST_LSB = 16;
  localparam int CMD_SPIMM_LSB = 24;
  localparam int CMD_WFLAG_LSB = 28;
  localparam int ST_WRITE_BIT = 31;
  localparam int ST_DEST_LSB = 24;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  typedef struct packed {
    logic zero;
    logic neg;
    logic carry;
    logic ovf;
  } ssu_flags_s;

  typedef struct packed {
    ssu_op_e op;
    logic [4:0] cc;
    logic setFlags;
    logic [5:0] dest;
    logic [4:0] spImm;
  } ssu_cmd_s;
endpackage : ssu_pkg

// >>> hdl/ssu_scaled_subtract_unit.sv
// scaled subtract datapath with avalon-mm register access
//
// Behaviour
// - plain subtract: src1 minus src2 to dest
// - scale-by-two: src2 shifted left one
// - scale-by-four: src2 shifted left two
// - scale-by-eight: src2 shifted left three
// - plain and scaled subtracts execute only when condition code true
// - zero flag set when result is zero
// - negative flag copies result bit 31
// - carry flag marks borrow of subtraction
// - overflow only from subtract step
// - flags change only with flag-set bit
// - short clear runs only when zero clear
// - stack immediate is five bits, word aligned
`timescale 1ns/1ps
module ssu_scaled_subtract_unit
  import ssu_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  logic rstSync1Reg;
  logic rstSyncReg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstSync1Reg <= 1'b0;
      rstSyncReg <= 1'b0;
    end else begin
      rstSync1Reg <= 1'b1;
      rstSyncReg <= rstSync1Reg;
    end
  end

  logic [31:0] src1Reg;
  logic [31:0] src2Reg;
  ssu_cmd_s cmdReg;
  ssu_flags_s flagsReg;
  logic [31:0] resultReg;
  logic wroteReg;
  logic [5:0] wroteDestReg;
  logic goReg;
  logic ackReg;

  // one wait cycle per access: answer on the second edge
  wire logic access = (read || write) && !ackReg;
  always_ff @(posedge clock or negedge rstSyncReg) begin
    if (!rstSyncReg) begin
      ackReg <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      ackReg <= access;
      waitrequest <= !access;
    end
  end

  // condition evaluation
  logic condTrue;
  always_comb begin
    unique case (cmdReg.cc)
      CC_ALWAYS: condTrue = 1'b1;
      CC_EQ: condTrue = flagsReg.zero;
      CC_NE: condTrue = !flagsReg.zero;
      CC_PL: condTrue = !flagsReg.neg;
      CC_MI: condTrue = flagsReg.neg;
      CC_CS: condTrue = flagsReg.carry;
      CC_CC: condTrue = !flagsReg.carry;
      CC_VS: condTrue = flagsReg.ovf;
      CC_VC: condTrue = !flagsReg.ovf;
      default: condTrue = 1'b0;
    endcase
  end

  // operand selection and scaling
  logic [31:0] opA;
  logic [31:0] opB;
  logic execOk;
  always_comb begin
    opA = src1Reg;
    opB = src2Reg;
    execOk = condTrue;
    unique case (cmdReg.op)
      SSU_OP_SUB: opB = src2Reg;
      SSU_OP_SUB_X2: opB = {src2Reg[30:0], 1'b0};
      SSU_OP_SUB_X4: opB = {src2Reg[29:0], 2'b00};
      SSU_OP_SUB_X8: opB = {src2Reg[28:0], 3'b000};
      SSU_OP_CLEAR_NE: begin
        opB = src1Reg;
        execOk = !flagsReg.zero;
      end
      SSU_OP_SP_IMM: begin
        opB = {25'h000_0000, cmdReg.spImm, SP_ALIGN_ZERO};
        execOk = 1'b1;
      end
      default: execOk = 1'b0;
    endcase
  end

  // carry out of the 33-bit subtract is the borrow
  wire logic [32:0] diffWide = {1'b0, opA} - {1'b0, opB};
  wire logic [31:0] diff = diffWide[31:0];
  wire logic borrow = diffWide[32];
  wire logic ovf = (opA[SIGN_BIT] != opB[SIGN_BIT]) &&
                   (diff[SIGN_BIT] != opA[SIGN_BIT]);
  wire logic [5:0] destSel = (cmdReg.op == SSU_OP_SP_IMM) ? STACK_PTR_IDX : cmdReg.dest;

  // register writes
  always_ff @(posedge clock or negedge rstSyncReg) begin
    if (!rstSyncReg) begin
      src1Reg <= 32'h0000_0000;
      src2Reg <= 32'h0000_0000;
      cmdReg <= '{op: SSU_OP_SUB, cc: CC_ALWAYS, setFlags: 1'b0, dest: 6'h00, spImm: 5'h00};
      goReg <= 1'b0;
    end else begin
      goReg <= 1'b0;
      if (write && ackReg) begin
        unique case (address)
          ADDR_SRC1: src1Reg <= writedata;
          ADDR_SRC2: src2Reg <= writedata;
          ADDR_CMD: begin
            cmdReg.op <= ssu_op_e'(writedata[CMD_OP_LSB +: 3]);
            cmdReg.cc <= writedata[CMD_CC_LSB +: 5];
            cmdReg.setFlags <= writedata[CMD_SETF_BIT];
            cmdReg.dest <= writedata[CMD_DEST_LSB +: REG_ADDR_W];
            cmdReg.spImm <= writedata[CMD_SPIMM_LSB +: SP_IMM_W];
            goReg <= 1'b1;
          end
          ADDR_RESULT: ;
          default: ;
        endcase
      end
    end
  end

  // execution: one cycle after the command write
  always_ff @(posedge clock or negedge rstSyncReg) begin
    if (!rstSyncReg) begin
      flagsReg <= FLAGS_RESET;
      resultReg <= 32'h0000_0000;
      wroteReg <= 1'b0;
      wroteDestReg <= 6'h00;
    end else if (goReg) begin
      wroteReg <= 1'b0;
      if (execOk) begin
        if (destSel != NO_RESULT_DEST) begin
          resultReg <= (cmdReg.op == SSU_OP_CLEAR_NE) ? 32'h0000_0000 : diff;
          wroteReg <= 1'b1;
          wroteDestReg <= destSel;
        end
        if (cmdReg.setFlags) begin
          flagsReg.zero <= (diff == 32'h0000_0000);
          flagsReg.neg <= diff[SIGN_BIT];
          flagsReg.carry <= borrow;
          flagsReg.ovf <= ovf;
        end
      end
    end
  end

  // read data
  always_ff @(posedge clock or negedge rstSyncReg) begin
    if (!rstSyncReg) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ackReg) begin
      unique case (address)
        ADDR_SRC1: readdata <= src1Reg;
        ADDR_SRC2: readdata <= src2Reg;
        ADDR_CMD: readdata <= {wroteReg, 1'b0, 2'b00, flagsReg, 24'h00_0000} |
                              {8'h00, 2'b00, wroteDestReg, 16'h0000};
        ADDR_RESULT: readdata <= resultReg;
        default: readdata <= UNMAPPED_READ;
      endcase
    end
  end

  default clocking assertClk @(posedge clock);
  endclocking
  default disable iff (!rstSyncReg);

  chk_zero_flag: assert property (
    goReg && execOk && cmdReg.setFlags |=> flagsReg.zero == ($past(diff) == 32'h0000_0000))
    else $error("zero flag mismatch");

  chk_neg_flag: assert property (
    goReg && execOk && cmdReg.setFlags |=> flagsReg.neg == $past(diff[SIGN_BIT]))
    else $error("negative flag mismatch");

  chk_carry_flag: assert property (
    goReg && execOk && cmdReg.setFlags |=> flagsReg.carry == $past(borrow))
    else $error("carry flag mismatch");

  chk_carry_ref: assert property (
    goReg && execOk && cmdReg.setFlags |=> flagsReg.carry == ($past(opA) < $past(opB)))
    else $error("carry is not the unsigned borrow");

  chk_ovf_flag: assert property (
    goReg && execOk && cmdReg.setFlags |=> flagsReg.ovf == $past(ovf))
    else $error("overflow flag mismatch");

  chk_ovf_ref: assert property (
    goReg && execOk && cmdReg.setFlags |=> flagsReg.ovf ==
    (($past(opA[SIGN_BIT]) != $past(opB[SIGN_BIT])) &&
     ($past(diff[SIGN_BIT]) != $past(opA[SIGN_BIT]))))
    else $error("overflow not from subtract step");

  chk_flags_hold: assert property (
    goReg && !(execOk && cmdReg.setFlags) |=> $stable(flagsReg))
    else $error("flags changed without set");

  chk_noflag_hold: assert property (
    goReg && !cmdReg.setFlags |=> $stable(flagsReg))
    else $error("flags changed with set bit clear");

  chk_cond_skip: assert property (
    goReg && !execOk |=> $stable(resultReg) && !wroteReg)
    else $error("skipped op wrote result");

  chk_cond_run: assert property (
    goReg && condTrue && cmdReg.op == SSU_OP_SUB && destSel != NO_RESULT_DEST |=> wroteReg)
    else $error("true condition did not write");

  chk_idle_quiet: assert property (
    !goReg |=> $stable(resultReg) && $stable(flagsReg))
    else $error("state changed without command");

  chk_null_dest: assert property (
    goReg && destSel == NO_RESULT_DEST |=> !wroteReg)
    else $error("null destination written");

  chk_null_result: assert property (
    goReg && destSel == NO_RESULT_DEST |=> $stable(resultReg))
    else $error("null destination changed result");

  chk_null_flags: assert property (
    goReg && execOk && destSel == NO_RESULT_DEST && cmdReg.setFlags
    |=> flagsReg.zero == ($past(diff) == 32'h0000_0000))
    else $error("null destination lost flag update");

  chk_plain_sub: assert property (
    goReg && execOk && cmdReg.op == SSU_OP_SUB && destSel != NO_RESULT_DEST
    |=> resultReg == $past(src1Reg) - $past(src2Reg))
    else $error("plain subtract wrong");

  chk_dest_record: assert property (
    goReg && execOk && destSel != NO_RESULT_DEST && cmdReg.op != SSU_OP_SP_IMM
    |=> wroteDestReg == $past(cmdReg.dest))
    else $error("destination index wrong");

  chk_scale_x2: assert property (
    goReg && execOk && cmdReg.op == SSU_OP_SUB_X2 && destSel != NO_RESULT_DEST
    |=> resultReg == $past(src1Reg) - ($past(src2Reg) << 1))
    else $error("scale-by-two result wrong");

  chk_scale_x4: assert property (
    goReg && execOk && cmdReg.op == SSU_OP_SUB_X4 && destSel != NO_RESULT_DEST
    |=> resultReg == $past(src1Reg) - ($past(src2Reg) << 2))
    else $error("scale-by-four result wrong");

  chk_scale_x8: assert property (
    goReg && execOk && cmdReg.op == SSU_OP_SUB_X8 && destSel != NO_RESULT_DEST
    |=> resultReg == $past(src1Reg) - ($past(src2Reg) << 3))
    else $error("scale-by-eight result wrong");

  chk_x2_low_bit: assert property (
    goReg && execOk && cmdReg.op == SSU_OP_SUB_X2 && destSel != NO_RESULT_DEST
    |=> resultReg[0] == $past(src1Reg[0]))
    else $error("scale-by-two low bit wrong");

  chk_x4_low_bits: assert property (
    goReg && execOk && cmdReg.op == SSU_OP_SUB_X4 && destSel != NO_RESULT_DEST
    |=> resultReg[1:0] == $past(src1Reg[1:0]))
    else $error("scale-by-four low bits wrong");

  chk_x8_low_bits: assert property (
    goReg && execOk && cmdReg.op == SSU_OP_SUB_X8 && destSel != NO_RESULT_DEST
    |=> resultReg[2:0] == $past(src1Reg[2:0]))
    else $error("scale-by-eight low bits wrong");

  chk_clear_skip: assert property (
    goReg && cmdReg.op == SSU_OP_CLEAR_NE && flagsReg.zero |=> !wroteReg && $stable(flagsReg))
    else $error("clear ran with zero set");

  chk_clear_run: assert property (
    goReg && cmdReg.op == SSU_OP_CLEAR_NE && !flagsReg.zero && destSel != NO_RESULT_DEST
    |=> wroteReg && resultReg == 32'h0000_0000)
    else $error("clear did not clear");

  chk_sp_dest: assert property (
    goReg && cmdReg.op == SSU_OP_SP_IMM |=> wroteDestReg == STACK_PTR_IDX
    && resultReg[1:0] == $past(src1Reg[1:0]))
    else $error("stack immediate wrong");

  chk_sp_result: assert property (
    goReg && cmdReg.op == SSU_OP_SP_IMM
    |=> resultReg == $past(src1Reg) - {25'h000_0000, $past(cmdReg.spImm), SP_ALIGN_ZERO})
    else $error("stack offset wrong");

  chk_bus_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest || !(read || write))
    else $error("bus answer late");

  chk_bus_release: assert property (
    !(read || write) |=> waitrequest)
    else $error("waitrequest low while idle");

  chk_read_data: assert property (
    read && !ackReg && address == ADDR_RESULT |=> readdata == $past(resultReg))
    else $error("result read data wrong");
endmodule : ssu_scaled_subtract_unit

// >>> tb/ssu_host_model.sv
// register bus master model for the subtract unit
`timescale 1ns/1ps
module ssu_host_model (
  input wire logic clock,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [3:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata
);
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
  end
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~d;
  endtask : xfer
endmodule : ssu_host_model

// >>> tb/tb.sv
// self-checking bench for the scaled subtract unit
`timescale 1ns/1ps
module tb;
  import ssu_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] address;
  logic read;
  logic write;
  logic waitrequest;
  logic [31:0] writedata;
  logic [31:0] readdata;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [3:0] fl = FLAGS_RESET;
  logic [31:0] res = 32'h0000_0000;
  always #50 clock = ~clock;
  ssu_scaled_subtract_unit ssu_scaled_subtract_unit_i (.clock(clock), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  ssu_host_model ssu_host_model_i (.clock(clock), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .writedata(writedata));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] e, input logic [31:0] m);
    n_tests++;
    if ((readdata & m) !== (e & m)) begin
      $display("CHECK FAILED readdata exp %h seen %h", e & m, readdata & m);
      bad_count++;
    end
  endtask : chk
  always @(posedge clock) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      chk(expQ.pop_front(), mskQ.pop_front());
    end
  end
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    ssu_host_model_i.xfer(1'b1, a, 32'h0000_0000);
  endtask : rd
  task automatic run(input logic [2:0] op, input logic [4:0] cc, input logic sf,
                     input logic [5:0] dst, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] ob;
    logic [31:0] d;
    logic ex;
    ob = op[2] ? (op[0] ? {25'h0, b[4:0], 2'h0} : a) : b << op[1:0];
    d = a - ob;
    case (cc)
      5'h00: ex = 1'b1;
      5'h01: ex = fl[3];
      5'h02: ex = !fl[3];
      5'h03: ex = !fl[2];
      5'h04: ex = fl[2];
      5'h05: ex = fl[1];
      5'h06: ex = !fl[1];
      5'h07: ex = fl[0];
      5'h08: ex = !fl[0];
      default: ex = 1'b0;
    endcase
    if (op == 3'h4) ex = !fl[3];
    if (op > 3'h5) ex = 1'b0;
    if (ex && dst != NO_RESULT_DEST) res = d;
    if (ex && sf) fl = {d == 0, d[31], a < ob, (a[31] != ob[31]) && (d[31] != a[31])};
    ssu_host_model_i.xfer(1'b0, ADDR_SRC1, a);
    ssu_host_model_i.xfer(1'b0, ADDR_SRC2, b);
    ssu_host_model_i.xfer(1'b0, ADDR_CMD,
      {3'h0, b[4:0], 2'h0, dst, 6'h0, sf, cc, 1'b0, op});
    rd(ADDR_RESULT, res, 32'hFFFF_FFFF);
    rd(ADDR_CMD, {4'h0, fl, 24'h0}, 32'h0F00_0000);
  endtask : run
  initial begin
    #500_000;
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(19));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(ADDR_CMD, {4'h0, FLAGS_RESET, 24'h0}, 32'h0F00_0000);
    rd(4'h2, UNMAPPED_READ, 32'hFFFF_FFFF);
    run(3'h0, CC_ALWAYS, 1'b1, 6'h01, 32'h0000_0005, 32'h0000_0005);
    run(3'h0, CC_ALWAYS, 1'b1, 6'h01, 32'h0000_0000, 32'hFFFF_FFFF);
    run(3'h0, CC_ALWAYS, 1'b1, 6'h01, 32'h8000_0000, 32'h0000_0001);
    run(3'h3, CC_ALWAYS, 1'b1, 6'h01, 32'h0000_0000, 32'hF000_0001);
    for (int k = 0; k < 24; k++) begin
      run(k[2:0] & 3'h3, CC_ALWAYS, 1'b1, 6'h01, $urandom, $urandom);
    end
    for (int c = 0; c < 10; c++) begin
      run(3'h0, c[4:0], 1'b1, 6'h02, $urandom, $urandom);
      run(3'h0, c[4:0], 1'b1, 6'h02, 32'h0000_0007, 32'h0000_0007);
    end
    run(3'h0, CC_ALWAYS, 1'b0, 6'h03, $urandom, $urandom);
    run(3'h0, CC_ALWAYS, 1'b1, NO_RESULT_DEST, 32'h0000_0001, 32'h0000_0009);
    run(3'h0, CC_ALWAYS, 1'b1, 6'h01, 32'h0000_0007, 32'h0000_0007);
    run(3'h4, CC_ALWAYS, 1'b0, 6'h04, $urandom, 32'h0000_0000);
    run(3'h0, CC_ALWAYS, 1'b1, 6'h01, 32'h0000_0009, 32'h0000_0007);
    run(3'h4, CC_ALWAYS, 1'b0, 6'h04, $urandom, 32'h0000_0000);
    run(3'h5, CC_ALWAYS, 1'b1, STACK_PTR_IDX, $urandom, 32'h0000_001F);
    run(3'h5, CC_ALWAYS, 1'b0, STACK_PTR_IDX, $urandom, $urandom);
    run(3'h6, CC_ALWAYS, 1'b1, 6'h05, $urandom, $urandom);
    repeat (4) @(posedge clock);
    stop_test();
  end
endmodule : tb
